/* File: pcw_pkg.sv */
// Constants and types of the paging code-word decoder.
// Assumes a single 250 MHz clock domain and a classic Wishbone host.
package pcw_pkg;
  // Code structure
  localparam int WORD_BITS = 32;
  localparam int WORDS_PER_BATCH = 17;
  localparam int FRAMES = 8;
  localparam int WORDS_PER_FRAME = 2;
  localparam int PRE_MIN_BITS = 576;
  localparam int PRE_MAX_ERR = 4;
  localparam int SYNC_MAX_ERR = 2;
  localparam logic [4:0] LAST_BIT = 5'h1f;
  localparam logic [4:0] LAST_WORD = 5'h10;
  localparam logic [31:0] SYNC_WORD = 32'h7cd215d8;
  localparam logic [31:0] IDLE_WORD = 32'h7a89c197;
  localparam logic [30:0] PRE_PATTERN = 31'h55555555;
  localparam logic [10:0] BCH_POLY = 11'h769;
  localparam logic [4:0] BURST_LAST_START = 5'h1c;
  localparam logic [3:0] CYCLE_SHORT = 4'h5;
  localparam logic [3:0] CYCLE_LONG = 4'hf;
  localparam logic [1:0] FUNC_NO_BCAST = 2'h3;
  localparam logic [1:0] FUNC_ALERT1 = 2'h1;
  localparam logic [1:0] FUNC_ALERT2 = 2'h2;
  localparam int N_IDENT = 2;
  localparam int N_CSYNC = 4;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_IDENT0 = 8'h0c;
  localparam logic [7:0] REG_IDENT1 = 8'h10;
  localparam logic [7:0] REG_CSYNC0 = 8'h14;
  localparam logic [7:0] REG_CSYNC3 = 8'h20;
  localparam logic [31:0] CTRL_RESET = 32'h0;
  // Control fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_APOC = 1;
  localparam int CTRL_BURST = 2;
  localparam int CTRL_CYC15 = 3;
  localparam int CTRL_ALLOC_LO = 4;
  localparam int CTRL_MARK_EN = 8;
  localparam int CTRL_MARK_SLOT = 9;
  localparam int CTRL_CSEN_LO = 12;
  localparam int CTRL_CDD_LO = 16;
  localparam int IDENT_EN = 31;
  localparam int STAT_OVF = 3;
  // Output word kinds and error categories
  localparam logic [2:0] KIND_ADDR = 3'h1;
  localparam logic [2:0] KIND_MSG = 3'h2;
  localparam logic [2:0] KIND_BCAST = 3'h3;
  localparam logic [2:0] KIND_RAW = 3'h4;
  localparam logic [2:0] KIND_MARK = 3'h5;
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_ONE = 3'h1;
  localparam logic [2:0] ERR_TWO = 3'h2;
  localparam logic [2:0] ERR_BURST = 3'h3;
  localparam logic [2:0] ERR_FAIL = 3'h4;
  typedef enum logic {ENG_IDLE, ENG_FIX} pcw_eng_t;
endpackage : pcw_pkg

/* File: pcw_decoder.sv */
// Paging code-word decoder: framing, correction, address match, output.
// Assumes rx pins come from a receiver on an unrelated clock; a bit is
// taken on each rising edge of rx_bit_clk_i, at most one per 1100 clocks.
`timescale 1ns/1ps
// What this block does
// - An alternating run is recognised as preamble ahead of the batches.
// - A batch is 17 words of 32 bits, the first being sync.
// - After sync, eight frames of two words each follow.
// - The idle word fills frames and ends a running message.
// - Top bit 0 marks an address word, 1 a message word.
// - Upper 18 identity bits are compared with word bits 2 to 19.
// - An identity matches only in the frame named by its low 3 bits.
// - Function bits 20 and 21 give the call type.
// - Unusual function and format pairings are decoded, never rejected.
// - Messages run across frames until idle, address or an uncorrectable word; alerts carry none.
// - Message payload is word bits 2 to 21.
// - Payload packs 4-bit digits or 7-bit characters by call type.
// - Each word is checked by its 10 check bits and even parity.
// - Two random errors corrected; optionally three within a 4-bit burst.
// - Preamble allows 4 errors in 31 bits, sync 2 in 32.
// - Every output word carries its error category.
// - A cycle marker right after sync starts a cycle of 5 or 15 batches.
// - In cycle mode addresses are searched only in the allocated batch.
// - Marker function 1,1 means no broadcast; else broadcast follows.
// - Broadcast words follow the marker of the first cycle after preamble.
// - Cycle mode is selectable; the marker sits in any identity slot.
// - Four custom sync words, each optionally starting continuous decoding.
module pcw_decoder (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Receiver pins
  input wire logic rx_data_i,
  input wire logic rx_bit_clk_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Status
  output logic synced_o,
  output logic word_ready_o
);
  import pcw_pkg::*;

  typedef struct packed {
    logic [1:0] d_sync;
    logic [1:0] c_sync;
    logic c_prev;
    logic [31:0] sh;
    logic ack;
    logic [31:0] dat;
    logic [31:0] ctrl;
    logic [N_IDENT-1:0][31:0] ident;
    logic [N_CSYNC-1:0][31:0] csync;
    logic synced;
    logic cont;
    logic pre_seen;
    logic first_cycle;
    logic cycle_known;
    logic in_msg;
    logic bcast;
    logic ovf;
    logic [4:0] bitc;
    logic [4:0] wordc;
    logic [3:0] batch;
    logic [1:0] call_func;
    logic call_slot;
    pcw_eng_t est;
    logic [31:0] raw;
    logic [3:0] pos;
    logic [4:0] ci;
    logic [4:0] cj;
    logic [1:0] ph;
    logic out_valid;
    logic [31:0] out;
  } pcw_st_t;

  pcw_st_t q;
  pcw_st_t n;

  function automatic logic [5:0] popcnt(input logic [31:0] x);
    logic [5:0] c;
    c = 6'h0;
    for (int i = 0; i < WORD_BITS; i++) begin
      c = c + {5'h0, x[i]};
    end
    return c;
  endfunction : popcnt

  // Remainder of the 31 leading bits by the generator, plus parity
  function automatic logic word_ok(input logic [31:0] w);
    logic [10:0] r;
    r = 11'h0;
    for (int i = 31; i >= 1; i--) begin
      r = {r[9:0], w[i]};
      if (r[10]) begin
        r = r ^ BCH_POLY;
      end
    end
    return (r[9:0] == 10'h0) && !(^w);
  endfunction : word_ok

  function automatic logic sync_hit(input logic [31:0] w,
                                    input logic [31:0] ref_w);
    return popcnt(w ^ ref_w) <= 6'(SYNC_MAX_ERR);
  endfunction : sync_hit

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  always_comb begin
    logic [31:0] nsh;
    logic [30:0] pre_x;
    logic bit_edge;
    logic std_hit;
    logic [N_CSYNC-1:0] c_hit;
    logic any_hit;
    logic cdd_hit;
    logic [31:0] pat;
    logic [31:0] fw;
    logic done;
    logic fail;
    logic [2:0] err;
    logic [2:0] frame;
    logic search_ok;
    logic mark_hit;
    logic emit;
    logic [31:0] emit_w;
    logic req;
    logic [31:0] rd;
    n = q;
    nsh = {q.sh[30:0], q.d_sync[1]};
    pre_x = nsh[30:0] ^ PRE_PATTERN;
    bit_edge = q.c_sync[1] && !q.c_prev;
    std_hit = sync_hit(nsh, SYNC_WORD);
    c_hit = '0;
    for (int k = 0; k < N_CSYNC; k++) begin
      c_hit[k] = q.ctrl[CTRL_CSEN_LO + k] &&
                 sync_hit(nsh, q.csync[k]);
    end
    any_hit = std_hit || (|c_hit);
    cdd_hit = |(c_hit & q.ctrl[CTRL_CDD_LO +: N_CSYNC]);
    pat = 32'h0;
    fw = 32'h0;
    done = 1'b0;
    fail = 1'b0;
    err = ERR_NONE;
    frame = 3'h0;
    search_ok = 1'b0;
    mark_hit = 1'b0;
    emit = 1'b0;
    emit_w = 32'h0;
    req = wb_cyc_i && wb_stb_i && !q.ack;
    rd = 32'h0;

    // Pin synchronisers
    n.d_sync = {q.d_sync[0], rx_data_i};
    n.c_sync = {q.c_sync[0], rx_bit_clk_i};
    n.c_prev = q.c_sync[1];

    // Bit framing
    if (!q.ctrl[CTRL_EN]) begin
      n.synced = 1'b0;
      n.cont = 1'b0;
      n.in_msg = 1'b0;
    end else if (bit_edge) begin
      n.sh = nsh;
      if ((popcnt({1'b0, pre_x}) <= 6'(PRE_MAX_ERR)) ||
          (popcnt({1'b0, ~pre_x}) <= 6'(PRE_MAX_ERR))) begin
        // Window match only; a run shorter than the minimum is accepted
        n.pre_seen = 1'b1;
        n.first_cycle = 1'b1;
      end
      if (!q.synced) begin
        if (any_hit) begin
          n.synced = 1'b1;
          n.bitc = 5'h0;
          n.wordc = 5'h1;
          n.cont = cdd_hit;
        end
      end else if (q.bitc != LAST_BIT) begin
        n.bitc = q.bitc + 5'h1;
      end else begin
        n.bitc = 5'h0;
        if (q.wordc == 5'h0) begin
          // Sync slot of a batch
          n.wordc = 5'h1;
          if (!any_hit) begin
            n.synced = 1'b0;
            n.cont = 1'b0;
            n.in_msg = 1'b0;
          end else if (cdd_hit) begin
            n.cont = 1'b1;
          end
          if (q.cycle_known) begin
            n.batch = (q.batch == (q.ctrl[CTRL_CYC15] ? CYCLE_LONG :
                       CYCLE_SHORT) - 4'h1) ? 4'h0 : q.batch + 4'h1;
          end
        end else begin
          n.wordc = (q.wordc == LAST_WORD) ? 5'h0 : q.wordc + 5'h1;
          // Engine finishes well inside one bit, so it is always free here
          if (q.est == ENG_IDLE) begin
            n.est = ENG_FIX;
            n.raw = nsh;
            n.pos = 4'(q.wordc - 5'h1);
            n.ph = 2'h0;
            n.ci = 5'h0;
            n.cj = 5'h0;
          end
        end
      end
    end

    // Correction by trial of error patterns
    if (q.est == ENG_FIX) begin
      unique case (q.ph)
        2'h0: pat = 32'h0;
        2'h1: pat = (32'h1 << q.ci) | (32'h1 << q.cj);
        default: pat = {28'h0, q.cj[3:0]} << q.ci;
      endcase
      fw = q.raw ^ pat;
      if (word_ok(fw) && !(q.ph == 2'h2 && q.cj[3:0] == 4'hf)) begin
        done = 1'b1;
        unique case (q.ph)
          2'h0: err = ERR_NONE;
          2'h1: err = (q.ci == q.cj) ? ERR_ONE : ERR_TWO;
          default: err = ERR_BURST;
        endcase
      end else if (q.ph == 2'h0) begin
        n.ph = 2'h1;
      end else if (q.ph == 2'h1) begin
        if (q.cj != LAST_BIT) begin
          n.cj = q.cj + 5'h1;
        end else if (q.ci != LAST_BIT) begin
          n.ci = q.ci + 5'h1;
          n.cj = q.ci + 5'h1;
        end else if (q.ctrl[CTRL_BURST]) begin
          n.ph = 2'h2;
          n.ci = 5'h0;
          n.cj = 5'h1;
        end else begin
          fail = 1'b1;
        end
      end else if (q.cj != 5'hf) begin
        n.cj = q.cj + 5'h1;
      end else if (q.ci != BURST_LAST_START) begin
        n.ci = q.ci + 5'h1;
        n.cj = 5'h1;
      end else begin
        fail = 1'b1;
      end
      if (fail) begin
        fw = q.raw;
        err = ERR_FAIL;
      end
    end

    // Word interpretation
    if (done || fail) begin
      n.est = ENG_IDLE;
      frame = q.pos[3:1];
      search_ok = !q.ctrl[CTRL_APOC] ||
                  (q.cycle_known && q.batch == q.ctrl[CTRL_ALLOC_LO +: 4]);
      mark_hit = q.ctrl[CTRL_APOC] && q.ctrl[CTRL_MARK_EN] && done &&
                 !fw[31] && q.pos == 4'h0 &&
                 fw[30:13] == q.ident[q.ctrl[CTRL_MARK_SLOT]][20:3];
      if (q.cont) begin
        if (fw != IDLE_WORD) begin
          emit = 1'b1;
          emit_w = {4'h0, KIND_RAW, err, fw[12:11], fw[30:11]};
        end
      end else if (fail) begin
        if (q.in_msg) begin
          emit = 1'b1;
          emit_w = {3'h0, q.call_slot, q.bcast ? KIND_BCAST : KIND_MSG,
                    err, q.call_func, fw[30:11]};
        end
        n.in_msg = 1'b0;
      end else if (mark_hit) begin
        // Cycle marker right after sync
        n.cycle_known = 1'b1;
        n.batch = 4'h0;
        n.first_cycle = 1'b0;
        n.in_msg = q.first_cycle && fw[12:11] != FUNC_NO_BCAST;
        n.bcast = 1'b1;
        n.call_func = fw[12:11];
        emit = 1'b1;
        emit_w = {4'h0, KIND_MARK, err, fw[12:11], fw[30:11]};
      end else if (fw == IDLE_WORD || !fw[31]) begin
        n.in_msg = 1'b0;
        if (!fw[31] && fw != IDLE_WORD && search_ok) begin
          for (int s = 0; s < N_IDENT; s++) begin
            if (q.ident[s][IDENT_EN] && frame == q.ident[s][2:0] &&
                fw[30:13] == q.ident[s][20:3] &&
                !(q.ctrl[CTRL_APOC] && q.ctrl[CTRL_MARK_EN] &&
                  q.ctrl[CTRL_MARK_SLOT] == s[0])) begin
              emit = 1'b1;
              // Function bits kept raw: unusual types still decode
              emit_w = {3'h0, s[0], KIND_ADDR, err, fw[12:11],
                        fw[30:11]};
              n.call_func = fw[12:11];
              n.call_slot = s[0];
              n.bcast = 1'b0;
              n.in_msg = fw[12:11] != FUNC_ALERT1 &&
                         fw[12:11] != FUNC_ALERT2;
            end
          end
        end
      end else if (q.in_msg) begin
        // Host unpacks 4-bit digits or 7-bit characters by function bits
        emit = 1'b1;
        emit_w = {3'h0, q.call_slot, q.bcast ? KIND_BCAST : KIND_MSG,
                  err, q.call_func, fw[30:11]};
      end
    end

    // Wishbone slave, one wait state
    n.ack = req;
    if (req) begin
      unique case (wb_adr_i)
        REG_CTRL: rd = q.ctrl;
        REG_STATUS: rd = {16'h0, 4'h0, q.batch, 2'h0, q.cycle_known, q.cont,
                          q.ovf, q.out_valid, q.pre_seen, q.synced};
        REG_DATA: rd = {q.out_valid, q.out[30:0]};
        REG_IDENT0: rd = q.ident[0];
        REG_IDENT1: rd = q.ident[1];
        REG_CSYNC0, 8'h18, 8'h1c, REG_CSYNC3:
          rd = q.csync[2'(wb_adr_i[4:2] - 3'h5)];
        default: rd = 32'h0;
      endcase
      n.dat = rd;
      if (wb_we_i) begin
        unique case (wb_adr_i)
          REG_CTRL: n.ctrl = merge(q.ctrl, wb_dat_i, wb_sel_i);
          REG_STATUS: begin
            if (wb_sel_i[0] && wb_dat_i[STAT_OVF]) begin
              n.ovf = 1'b0;
            end
          end
          REG_IDENT0: n.ident[0] = merge(q.ident[0], wb_dat_i, wb_sel_i);
          REG_IDENT1: n.ident[1] = merge(q.ident[1], wb_dat_i, wb_sel_i);
          REG_CSYNC0, 8'h18, 8'h1c, REG_CSYNC3:
            n.csync[2'(wb_adr_i[4:2] - 3'h5)] =
              merge(q.csync[2'(wb_adr_i[4:2] - 3'h5)], wb_dat_i, wb_sel_i);
          default: n.dat = rd;
        endcase
      end else if (wb_adr_i == REG_DATA) begin
        n.out_valid = 1'b0;
      end
    end

    // New word wins over a pop or overflow clear in the same cycle
    if (emit) begin
      n.out = emit_w;
      n.out_valid = 1'b1;
      if (q.out_valid && !(req && !wb_we_i && wb_adr_i == REG_DATA)) begin
        n.ovf = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ctrl <= CTRL_RESET;
      q.est <= ENG_IDLE;
    end else begin
      q <= n;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
  assign synced_o = q.synced;
  assign word_ready_o = q.out_valid;
endmodule : pcw_decoder

/* File: pcw_checker.sv */
// Port assertions for the paging code-word decoder.
// Assumes it is bound to pcw_decoder and sees only that module's ports.
`timescale 1ns/1ps
module pcw_checker
  import pcw_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Receiver pins
  input wire logic rx_data_i,
  input wire logic rx_bit_clk_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Status
  input wire logic synced_o,
  input wire logic word_ready_o
);
  localparam int READY_MAX = 1500;
  logic [11:0] since_bit;
  logic bit_q;
  logic take_rd;
  assign take_rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  // Saturates so a stale word can never look recent
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_q <= 1'b0;
      since_bit <= 12'hfff;
    end else begin
      bit_q <= rx_bit_clk_i;
      if (rx_bit_clk_i && !bit_q)
        since_bit <= 12'h0;
      else if (since_bit != 12'hfff)
        since_bit <= since_bit + 12'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("request not answered next cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_unmapped_zero: assert property (take_rd && wb_adr_i > REG_CSYNC3
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_status_sync: assert property (
    take_rd && wb_adr_i == REG_STATUS |=> wb_dat_o[0] == $past(synced_o))
    else $error("status lock bit differs from pin");
  a_data_valid: assert property (
    take_rd && wb_adr_i == REG_DATA |=> wb_dat_o[31] == $past(word_ready_o))
    else $error("data valid bit differs from pin");
  a_ready_synced: assert property ($rose(word_ready_o) |-> synced_o)
    else $error("word output while unlocked");
  a_ready_after_bit: assert property (
    $rose(word_ready_o) |-> since_bit <= READY_MAX)
    else $error("word output long after last bit");
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_sync: cover property ($rose(synced_o));
  c_word: cover property ($rose(word_ready_o));
endmodule : pcw_checker

bind pcw_decoder pcw_checker chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .rx_data_i(rx_data_i),
  .rx_bit_clk_i(rx_bit_clk_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .synced_o(synced_o), .word_ready_o(word_ready_o)
);

/* File: pcw_rx_model.sv */
// Paging receiver model: serial data plus a bit clock.
// Assumes the caller hands whole 32-bit words, one call per word.
`timescale 1ns/1ps
module pcw_rx_model (
  // Clock
  input wire logic clk_i,
  // Receiver pins
  output logic rx_data_o,
  output logic rx_bit_clk_o
);
  initial begin
    rx_data_o = 1'b0;
    rx_bit_clk_o = 1'b0;
  end
  // 1101 clocks per bit, just above the decoder's minimum spacing
  task automatic send_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk_i);
      rx_data_o <= w[i];
      repeat (550) @(posedge clk_i);
      rx_bit_clk_o <= 1'b1;
      repeat (550) @(posedge clk_i);
      rx_bit_clk_o <= 1'b0;
    end
    // Released line must not keep showing the last bit
    rx_data_o <= ~w[0];
  endtask : send_word
endmodule : pcw_rx_model

/* File: paging_codeword_decoder_bench.sv */
// Self-checking bench for the paging code-word decoder.
// Assumes pcw_checker is bound in and pcw_rx_model feeds the pins.
`timescale 1ns/1ps
module paging_codeword_decoder_bench;
  import pcw_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, w, ac;
  logic ack, synced, ready, rx_d, rx_c;
  logic [20:0] id;
  logic [31:0] exp_q[$], msk_q[$];
  int fails = 0, n_checks = 0, p;

  initial forever #2 clk_i = ~clk_i;

  pcw_decoder dut_u (.clk_i(clk_i), .rst_i(rst_i), .rx_data_i(rx_d),
    .rx_bit_clk_i(rx_c), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .synced_o(synced), .word_ready_o(ready));
  pcw_rx_model rx_u (.clk_i(clk_i), .rx_data_o(rx_d), .rx_bit_clk_o(rx_c));

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  // Holds the request until ack is sampled high, then releases
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) check("ack", 32'(ack), 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask : rd

  task automatic wait_sig(input logic want_sync);
    int n;
    n = 0;
    while ((want_sync ? synced : ready) !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_sig

  function automatic logic [31:0] cw_of(input logic [20:0] d);
    logic [30:0] r;
    r = {d, 10'h0};
    for (int i = 30; i >= 10; i--)
      if (r[i]) r[i-:11] = r[i-:11] ^ BCH_POLY;
    return {d, r[9:0], ^{d, r[9:0]}};
  endfunction : cw_of

  // Oldest note is matched against each read answer
  always @(posedge clk_i) begin : mon
    logic [31:0] e, m;
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) begin
        check("spurious read", 32'h0, 32'h1);
      end else begin
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        check("read", rdat & m, e & m);
      end
    end
  end

  initial begin
    void'($urandom(85));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a <= 36; a += 4) rd(8'(a), 32'h0, '1);
    bus(1'b1, 8'hfc, 32'hffffffff, 4'hf);
    rd(8'hfc, 32'h0, '1);
    bus(1'b1, REG_STATUS, 32'hfffffff7, 4'hf);
    rd(REG_STATUS, 32'h0, '1);
    w = $urandom;
    bus(1'b1, REG_CSYNC3, w, 4'hf);
    rd(REG_CSYNC3, w, '1);
    bus(1'b1, REG_CTRL, 32'hffffffff, 4'h2);
    rd(REG_CTRL, 32'h0000ff00, '1);
    id = 21'($urandom) & 21'h1ffff8;
    bus(1'b1, REG_IDENT0, {1'b1, 10'h0, id}, 4'hf);
    bus(1'b1, REG_CTRL, 32'h1, 4'hf);
    p = $urandom_range(31, 0);
    rx_u.send_word(SYNC_WORD ^ (32'h1 << p) ^ (32'h1 << ((p + 7) % 32)));
    wait_sig(1'b1);
    check("synced", 32'(synced), 32'h1);
    rd(REG_STATUS, 32'h1, 32'h1);
    // Frame 0 numeric address with one flipped bit
    ac = cw_of({1'b0, id[20:3], 2'b00});
    rx_u.send_word(ac ^ (32'h1 << $urandom_range(31, 0)));
    wait_sig(1'b0);
    check("ready", 32'(ready), 32'h1);
    rd(REG_DATA, {4'h8, KIND_ADDR, ERR_ONE, ac[12:11], ac[30:11]},
       32'h9fffffff);
    @(posedge clk_i);
    check("pop", 32'(ready), 32'h0);
    w = cw_of({1'b1, 20'($urandom)});
    p = $urandom_range(31, 0);
    rx_u.send_word(w ^ (32'h1 << p) ^ (32'h1 << ((p + 13) % 32)));
    wait_sig(1'b0);
    check("msg ready", 32'(ready), 32'h1);
    rd(REG_DATA, {4'h8, KIND_MSG, ERR_TWO, 2'b00, w[30:11]},
       32'h9fcfffff);
    end_of_test();
  end

  initial begin
    repeat (110000) @(posedge clk_i);
    check("timeout", 32'h0, 32'h1);
    end_of_test();
  end
endmodule : paging_codeword_decoder_bench
